// ==== banked_registers_mode_control.sv ====
`timescale 1ns/10ps
module banked_registers_mode_control (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic big_endian_i,
	input wire logic program_space_wide_select_i,
	input wire logic data_space_wide_select_i,
	input wire logic irq_req_i,
	input wire logic fiq_req_i,
	input wire logic acc_valid_i,
	input wire logic acc_byte_i,
	input wire logic [1:0] acc_addr_i,
	output logic [3:0] lane_en_o,
	output logic [4:0] mode_o,
	output logic user_mode_o,
	output logic irq_pending_o,
	output logic fiq_pending_o,
	output logic cond_pass_o,
	output logic [2:0] config_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [core_regs_pkg::GPR_COUNT-1:0][31:0] gpr;
		logic [core_regs_pkg::SAVED_COUNT-1:0][31:0] saved;
		logic [31:0] status;
		logic [31:0] rdata;
		logic [2:0] cfg;
		logic irq_pend;
		logic fiq_pend;
		logic cond_pass;
		logic user_mode;
	} regs_s;

	regs_s s_d;
	regs_s s_q;
	logic [4:0] view_idx;
	logic [4:0] lr_idx;
	logic [4:0] cur_mode;
	logic privileged;
	logic [2:0] cur_slot;

	assign cur_mode = s_q.status[4:0];
	assign privileged = cur_mode != core_regs_pkg::MODE_USER;
	assign cur_slot = core_regs_pkg::mode_slot(cur_mode);

	// ------------------------------------------------------------
	// banked view decode
	// ------------------------------------------------------------
	// register port access, viewed through the current mode
	bank_select u_view (
		.mode_i(cur_mode),
		.reg_i(addr_i[5:2]),
		.phys_o(view_idx)
	);

	// link register of the current mode for branch-with-link
	bank_select u_link (
		.mode_i(cur_mode),
		.reg_i(4'hE),
		.phys_o(lr_idx)
	);

	// ------------------------------------------------------------
	// byte lanes for loads and stores
	// ------------------------------------------------------------
	// the byte order is used here and also sampled into the configuration straps
	byte_lanes u_lanes (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.big_endian_i(big_endian_i),
		.acc_valid_i(acc_valid_i),
		.acc_byte_i(acc_byte_i),
		.acc_addr_i(acc_addr_i),
		.lane_en_o(lane_en_o)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [2:0] kind;
		logic [4:0] new_mode;
		logic [31:0] wr_status;
		kind = wdata_i[2:0];
		new_mode = core_regs_pkg::kind_mode(kind);
		wr_status = s_q.status;
		s_d = s_q;
		s_d.rdata = 32'h00000000;
		// configuration straps are sampled live, no reset needed to change them
		s_d.cfg = {big_endian_i, program_space_wide_select_i, data_space_wide_select_i};
		// mask gates the request one cycle before it leaves the block
		s_d.irq_pend = irq_req_i && !s_q.status[core_regs_pkg::IRQ_MASK_BIT];
		s_d.fiq_pend = fiq_req_i && !s_q.status[core_regs_pkg::FIQ_MASK_BIT];

		// writes
		if (wr_i) begin
			if (addr_i[7:6] == 2'h0) begin
				if (addr_i[5:2] == 4'hF) begin
					s_d.gpr[core_regs_pkg::PC_INDEX] = {wdata_i[31:2], 2'h0};
				end else begin
					s_d.gpr[view_idx] = wdata_i;
				end
			end else begin
				case (addr_i)
					core_regs_pkg::CUR_STATUS_OFF: begin
						// flags are open to all; control bits only when privileged
						wr_status[31:core_regs_pkg::CTRL_BITS] = wdata_i[31:core_regs_pkg::CTRL_BITS];
						if (privileged) begin
							wr_status[core_regs_pkg::CTRL_BITS-1:0] = wdata_i[core_regs_pkg::CTRL_BITS-1:0];
						end
						// an undefined mode code would fall back to the user register view, keep the old one
						if (!core_regs_pkg::mode_valid(wr_status[4:0])) begin
							wr_status[4:0] = cur_mode;
						end
						s_d.status = wr_status;
					end
					core_regs_pkg::SAVED_STATUS_OFF: begin
						if (privileged) begin
							s_d.saved[cur_slot] = wdata_i;
						end
					end
					core_regs_pkg::EXC_ENTRY_OFF: begin
						if (kind <= core_regs_pkg::EXC_UND) begin
							s_d.saved[kind] = s_q.status;
							case (kind)
								core_regs_pkg::EXC_FIQ: s_d.gpr[core_regs_pkg::FIQ_BANK_BASE + 5'h06] =
									s_q.gpr[core_regs_pkg::PC_INDEX] + core_regs_pkg::WORD_STEP;
								core_regs_pkg::EXC_IRQ: s_d.gpr[core_regs_pkg::IRQ_BANK_BASE + 5'h01] =
									s_q.gpr[core_regs_pkg::PC_INDEX] + core_regs_pkg::WORD_STEP;
								core_regs_pkg::EXC_SVC: s_d.gpr[core_regs_pkg::SVC_BANK_BASE + 5'h01] =
									s_q.gpr[core_regs_pkg::PC_INDEX] + core_regs_pkg::WORD_STEP;
								core_regs_pkg::EXC_ABT: s_d.gpr[core_regs_pkg::ABT_BANK_BASE + 5'h01] =
									s_q.gpr[core_regs_pkg::PC_INDEX] + core_regs_pkg::WORD_STEP;
								default: s_d.gpr[core_regs_pkg::UND_BANK_BASE + 5'h01] =
									s_q.gpr[core_regs_pkg::PC_INDEX] + core_regs_pkg::WORD_STEP;
							endcase
							s_d.status[4:0] = new_mode;
							s_d.status[core_regs_pkg::IRQ_MASK_BIT] = 1'b1;
							if (kind == core_regs_pkg::EXC_FIQ) begin
								s_d.status[core_regs_pkg::FIQ_MASK_BIT] = 1'b1;
							end
						end
					end
					core_regs_pkg::LINK_CMD_OFF: begin
						s_d.gpr[lr_idx] = s_q.gpr[core_regs_pkg::PC_INDEX];
					end
					core_regs_pkg::COND_TEST_OFF: begin
						s_d.cond_pass = core_regs_pkg::cond_eval(wdata_i[3:0],
							s_q.status[31:core_regs_pkg::CTRL_BITS]);
					end
					default: begin
						s_d.cond_pass = s_q.cond_pass;
					end
				endcase
			end
		end

		// reads answer one cycle later; unmapped offsets read zero
		if (rd_i) begin
			if (addr_i[7:6] == 2'h0) begin
				if (addr_i[5:2] == 4'hF) begin
					s_d.rdata = {s_q.gpr[core_regs_pkg::PC_INDEX][31:2], 2'h0};
				end else begin
					s_d.rdata = s_q.gpr[view_idx];
				end
			end else begin
				case (addr_i)
					core_regs_pkg::CUR_STATUS_OFF: s_d.rdata = s_q.status;
					core_regs_pkg::SAVED_STATUS_OFF: s_d.rdata = privileged ? s_q.saved[cur_slot] : 32'h00000000;
					core_regs_pkg::CONFIG_OFF: s_d.rdata = {26'h0000000, s_q.fiq_pend, s_q.irq_pend,
						s_q.cond_pass, s_q.cfg};
					default: s_d.rdata = 32'h00000000;
				endcase
			end
		end
		// registered so that the user indication leaves the block from a flip-flop
		s_d.user_mode = s_d.status[4:0] == core_regs_pkg::MODE_USER;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.status <= core_regs_pkg::STATUS_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign mode_o = s_q.status[4:0];
	assign user_mode_o = s_q.user_mode;
	assign irq_pending_o = s_q.irq_pend;
	assign fiq_pending_o = s_q.fiq_pend;
	assign cond_pass_o = s_q.cond_pass;
	assign config_o = s_q.cfg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_pc_low_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_i && addr_i == 8'h3C |=> rdata_o[1:0] == 2'h0)
		else $error("pc read with nonzero low bits");

	a_mode_always_valid: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		core_regs_pkg::mode_valid(mode_o))
		else $error("mode field holds an undefined code");

	a_fiq_entry_masks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_i && addr_i == core_regs_pkg::EXC_ENTRY_OFF && wdata_i[2:0] == 3'h0
		|=> mode_o == 5'h11 && s_q.status[7] && s_q.status[6])
		else $error("fiq entry did not force mode and masks");

	a_irq_entry_fmask: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_i && addr_i == core_regs_pkg::EXC_ENTRY_OFF && wdata_i[2:0] == 3'h1
		|=> mode_o == 5'h12 && s_q.status[7] && s_q.status[6] == $past(s_q.status[6]))
		else $error("irq entry wrong mode or touched fiq mask");

	a_entry_saves_status: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_i && addr_i == core_regs_pkg::EXC_ENTRY_OFF && wdata_i[2:0] == 3'h3
		|=> s_q.saved[3] == $past(s_q.status) && s_q.gpr[28] == $past(s_q.gpr[15]) + 32'h00000004)
		else $error("abort entry lost status or return address");

	a_user_ctrl_lock: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		user_mode_o && wr_i && addr_i == core_regs_pkg::CUR_STATUS_OFF
		|=> s_q.status[27:0] == $past(s_q.status[27:0]) && s_q.status[31:28] == $past(wdata_i[31:28]))
		else $error("user mode changed control bits");

	a_irq_mask_blocks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_q.status[7] && s_q.status[6] |=> !irq_pending_o && !fiq_pending_o)
		else $error("masked interrupt request passed");

	a_user_saved_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		user_mode_o && rd_i && addr_i == core_regs_pkg::SAVED_STATUS_OFF |=> rdata_o == 32'h00000000)
		else $error("saved word readable in user mode");

	a_link_copies_pc: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_i && addr_i == core_regs_pkg::LINK_CMD_OFF && mode_o == 5'h10
		|=> s_q.gpr[14] == $past(s_q.gpr[15]))
		else $error("branch-link did not copy pc");

	a_fiq_bank_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_i && !wr_i && mode_o == 5'h11 && addr_i == 8'h20 |=> rdata_o == $past(s_q.gpr[16]))
		else $error("fiq view of r8 not banked");

	a_big_byte_lane: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		acc_valid_i && acc_byte_i && big_endian_i && acc_addr_i == 2'h0 |=> lane_en_o == 4'h8)
		else $error("big-endian byte 0 not on top lane");

	a_little_byte_lane: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		acc_valid_i && acc_byte_i && !big_endian_i && acc_addr_i == 2'h0 |=> lane_en_o == 4'h1)
		else $error("little-endian byte 0 not on low lane");

	a_word_all_lanes: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		acc_valid_i && !acc_byte_i |=> lane_en_o == 4'hF)
		else $error("word access did not enable all lanes");

	a_lanes_idle_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!acc_valid_i |=> lane_en_o == 4'h0)
		else $error("lanes enabled without an access");

	a_cfg_follows_pins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		1'b1 |=> config_o == $past({big_endian_i, program_space_wide_select_i, data_space_wide_select_i}))
		else $error("configuration inputs not followed");

	a_fiq_mask_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_q.status[6] |=> !fiq_pending_o)
		else $error("fiq passed while masked");

	a_irq_mask_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_q.status[7] |=> !irq_pending_o)
		else $error("irq passed while masked");

	a_irq_unmasked_pass: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		irq_req_i && !s_q.status[7] |=> irq_pending_o)
		else $error("unmasked irq request lost");

	a_und_entry_link: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_i && addr_i == core_regs_pkg::EXC_ENTRY_OFF && wdata_i[2:0] == 3'h4
		|=> s_q.saved[4] == $past(s_q.status) && s_q.gpr[30] == $past(s_q.gpr[15]) + 32'h00000004)
		else $error("undefined entry lost status or return address");

	a_user_saved_wr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		user_mode_o && wr_i && addr_i == core_regs_pkg::SAVED_STATUS_OFF |=> s_q.saved == $past(s_q.saved))
		else $error("saved word written in user mode");

	a_mode_switch_view: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_i && addr_i == core_regs_pkg::CUR_STATUS_OFF && !user_mode_o && core_regs_pkg::mode_valid(wdata_i[4:0])
		|=> mode_o == $past(wdata_i[4:0]))
		else $error("privileged mode write not applied");

	a_irq_bank_lr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_i && !wr_i && mode_o == 5'h12 && addr_i == 8'h38 |=> rdata_o == $past(s_q.gpr[24]))
		else $error("irq view of lr not banked");

	a_pc_write_align: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_i && addr_i == 8'h3C |=> s_q.gpr[15][1:0] == 2'h0)
		else $error("pc stored with nonzero low bits");

	a_cond_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!(wr_i && addr_i == core_regs_pkg::COND_TEST_OFF) |=> $stable(cond_pass_o))
		else $error("condition result changed without a test");

	a_user_flag_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		user_mode_o == (mode_o == 5'h10))
		else $error("user indication disagrees with mode");

	a_rdata_idle_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 32'h00000000)
		else $error("read data stood without a read");

endmodule

// ==== core_regs_pkg.sv ====
package core_regs_pkg;

	// ------------------------------------------------------------
	// register port offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] GPR_BASE_OFF = 8'h00; // 0x00..0x3C: visible r0..r15
	localparam logic [7:0] CUR_STATUS_OFF = 8'h40;
	localparam logic [7:0] SAVED_STATUS_OFF = 8'h44;
	localparam logic [7:0] CONFIG_OFF = 8'h48;
	localparam logic [7:0] EXC_ENTRY_OFF = 8'h4C;
	localparam logic [7:0] LINK_CMD_OFF = 8'h50;
	localparam logic [7:0] COND_TEST_OFF = 8'h54;

	// ------------------------------------------------------------
	// mode encodings
	// ------------------------------------------------------------
	localparam logic [4:0] MODE_USER = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1B;

	// ------------------------------------------------------------
	// status word fields
	// ------------------------------------------------------------
	localparam int FLAG_N_BIT = 31;
	localparam int FLAG_Z_BIT = 30;
	localparam int FLAG_C_BIT = 29;
	localparam int FLAG_V_BIT = 28;
	localparam int IRQ_MASK_BIT = 7;
	localparam int FIQ_MASK_BIT = 6;
	localparam int CTRL_BITS = 28;
	localparam logic [31:0] STATUS_RESET = 32'h000000D3; // supervisor, both masks set

	// ------------------------------------------------------------
	// register file geometry and physical indices
	// ------------------------------------------------------------
	localparam int GPR_COUNT = 31;
	localparam int SAVED_COUNT = 5;
	localparam logic [4:0] PC_INDEX = 5'h0F;
	localparam logic [4:0] FIQ_BANK_BASE = 5'h10; // r8_fiq..r14_fiq at 16..22
	localparam logic [4:0] IRQ_BANK_BASE = 5'h17;
	localparam logic [4:0] SVC_BANK_BASE = 5'h19;
	localparam logic [4:0] ABT_BANK_BASE = 5'h1B;
	localparam logic [4:0] UND_BANK_BASE = 5'h1D;
	localparam logic [31:0] WORD_STEP = 32'h00000004;

	// exception kinds written to the entry command, also saved-word slots
	localparam logic [2:0] EXC_FIQ = 3'h0;
	localparam logic [2:0] EXC_IRQ = 3'h1;
	localparam logic [2:0] EXC_SVC = 3'h2;
	localparam logic [2:0] EXC_ABT = 3'h3;
	localparam logic [2:0] EXC_UND = 3'h4;

	// only the six listed encodings count as a mode
	function automatic logic mode_valid(input logic [4:0] m);
		return (m == MODE_USER) || (m == MODE_FIQ) || (m == MODE_IRQ) ||
			(m == MODE_SVC) || (m == MODE_ABT) || (m == MODE_UND);
	endfunction

	// saved-word slot of a privileged mode
	function automatic logic [2:0] mode_slot(input logic [4:0] m);
		case (m)
			MODE_FIQ: return EXC_FIQ;
			MODE_IRQ: return EXC_IRQ;
			MODE_SVC: return EXC_SVC;
			MODE_ABT: return EXC_ABT;
			default: return EXC_UND;
		endcase
	endfunction

	// mode that an exception kind enters
	function automatic logic [4:0] kind_mode(input logic [2:0] k);
		case (k)
			EXC_FIQ: return MODE_FIQ;
			EXC_IRQ: return MODE_IRQ;
			EXC_SVC: return MODE_SVC;
			EXC_ABT: return MODE_ABT;
			default: return MODE_UND;
		endcase
	endfunction

	// execution condition against the n z c v flags
	function automatic logic cond_eval(input logic [3:0] c, input logic [3:0] f);
		logic n;
		logic z;
		logic cy;
		logic v;
		n = f[3];
		z = f[2];
		cy = f[1];
		v = f[0];
		case (c)
			4'h0: return z;
			4'h1: return !z;
			4'h2: return cy;
			4'h3: return !cy;
			4'h4: return n;
			4'h5: return !n;
			4'h6: return v;
			4'h7: return !v;
			4'h8: return cy && !z;
			4'h9: return !cy || z;
			4'hA: return n == v;
			4'hB: return n != v;
			4'hC: return !z && (n == v);
			4'hD: return z || (n != v);
			4'hE: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

endpackage

// ==== bank_select.sv ====
`timescale 1ns/10ps
// maps a visible register number to its physical slot for a mode
module bank_select (
	input wire logic [4:0] mode_i,
	input wire logic [3:0] reg_i,
	output logic [4:0] phys_o
);

	// -------------------------------------------------------------
	// banking decode
	// -------------------------------------------------------------
	// r0..r7 and the pc are never banked; unknown modes fall back to user
	always_comb begin
		phys_o = {1'b0, reg_i};
		if (reg_i != 4'hF) begin
			if (mode_i == core_regs_pkg::MODE_FIQ && reg_i >= 4'h8) begin
				phys_o = core_regs_pkg::FIQ_BANK_BASE + 5'(reg_i - 4'h8);
			end else if (reg_i == 4'hD || reg_i == 4'hE) begin
				// sp sits at the bank base and lr one above, as exception entry expects
				case (mode_i)
					core_regs_pkg::MODE_IRQ: phys_o = core_regs_pkg::IRQ_BANK_BASE + {4'h0, reg_i == 4'hE};
					core_regs_pkg::MODE_SVC: phys_o = core_regs_pkg::SVC_BANK_BASE + {4'h0, reg_i == 4'hE};
					core_regs_pkg::MODE_ABT: phys_o = core_regs_pkg::ABT_BANK_BASE + {4'h0, reg_i == 4'hE};
					core_regs_pkg::MODE_UND: phys_o = core_regs_pkg::UND_BANK_BASE + {4'h0, reg_i == 4'hE};
					default: phys_o = {1'b0, reg_i};
				endcase
			end
		end
	end

endmodule

// ==== byte_lanes.sv ====
`timescale 1ns/10ps
// byte-lane enables of a load or store, chosen by the byte order
module byte_lanes (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic big_endian_i,
	input wire logic acc_valid_i,
	input wire logic acc_byte_i,
	input wire logic [1:0] acc_addr_i,
	output logic [3:0] lane_en_o
);

	typedef struct packed {
		logic [3:0] lane_en;
	} lanes_s;

	lanes_s s_d;
	lanes_s s_q;

	// -------------------------------------------------------------
	// lane decode
	// -------------------------------------------------------------
	// words ignore the low address bits, so they are always aligned
	always_comb begin
		s_d = s_q;
		s_d.lane_en = 4'h0;
		if (acc_valid_i) begin
			if (!acc_byte_i) begin
				s_d.lane_en = 4'hF;
			end else if (big_endian_i) begin
				s_d.lane_en = 4'h8 >> acc_addr_i;
			end else begin
				s_d.lane_en = 4'h1 << acc_addr_i;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign lane_en_o = s_q.lane_en;

endmodule

// ==== mem_lanes_model.sv ====
`timescale 1ns/10ps
// far-side memory: works out which data lanes carry an addressed byte
module mem_lanes_model (
	input wire logic sys_clk_i,
	input wire logic big_endian_i,
	input wire logic acc_valid_i,
	input wire logic acc_byte_i,
	input wire logic [1:0] acc_addr_i,
	output logic [3:0] lane_expect_o
);
	// -------------------------------------------------
	// lane wiring
	// -------------------------------------------------
	// registered so that it lines up with the block's one-cycle answer
	always_ff @(posedge sys_clk_i) begin
		if (!acc_valid_i) begin
			lane_expect_o <= 4'h0;
		end else if (!acc_byte_i) begin
			lane_expect_o <= 4'hF;
		end else if (big_endian_i) begin
			lane_expect_o <= 4'h8 >> acc_addr_i;
		end else begin
			lane_expect_o <= 4'h1 << acc_addr_i;
		end
	end
endmodule

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h00000000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic big_endian_i = 1'b0;
	logic program_space_wide_select_i = 1'b1;
	logic data_space_wide_select_i = 1'b1;
	logic irq_req_i = 1'b0;
	logic fiq_req_i = 1'b0;
	logic acc_valid_i = 1'b0;
	logic acc_byte_i = 1'b0;
	logic [1:0] acc_addr_i = 2'h0;
	logic [31:0] rdata_o;
	logic [3:0] lane_en_o;
	logic [3:0] lane_expect;
	logic [4:0] mode_o;
	logic user_mode_o;
	logic irq_pending_o;
	logic fiq_pending_o;
	logic cond_pass_o;
	logic [2:0] config_o;
	logic [31:0] rv;
	int n_fail = 0;
	int n_compared = 0;
	// privileged modes in entry-kind order, then user
	logic [4:0] mlist [6] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h10};

	banked_registers_mode_control dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .big_endian_i(big_endian_i),
		.program_space_wide_select_i(program_space_wide_select_i), .data_space_wide_select_i(data_space_wide_select_i),
		.irq_req_i(irq_req_i), .fiq_req_i(fiq_req_i), .acc_valid_i(acc_valid_i), .acc_byte_i(acc_byte_i),
		.acc_addr_i(acc_addr_i), .lane_en_o(lane_en_o), .mode_o(mode_o), .user_mode_o(user_mode_o),
		.irq_pending_o(irq_pending_o), .fiq_pending_o(fiq_pending_o), .cond_pass_o(cond_pass_o), .config_o(config_o));

	mem_lanes_model mem (.sys_clk_i(sys_clk_i), .big_endian_i(big_endian_i), .acc_valid_i(acc_valid_i),
		.acc_byte_i(acc_byte_i), .acc_addr_i(acc_addr_i), .lane_expect_o(lane_expect));

	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// -------------------------------------------------
	// shared tasks
	// -------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one-cycle write strobe; returns just after the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe edge
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		rv = rdata_o;
		chk(what, exp, rv);
	endtask

	function automatic logic [7:0] gpr(input int n);
		return core_regs_pkg::GPR_BASE_OFF + 8'(n * 4);
	endfunction

	task automatic stop_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// -------------------------------------------------
	// scenarios
	// -------------------------------------------------
	task automatic t_reset;
		rchk("status", core_regs_pkg::CUR_STATUS_OFF, 32'h000000D3);
		chk("mode", 32'h13, 32'(mode_o));
		chk("config", 32'h3, 32'(config_o));
		$display("test reset done");
	endtask

	task automatic t_modes;
		for (int i = 0; i < 5; i++) begin
			wr(core_regs_pkg::CUR_STATUS_OFF, 32'hC0 | 32'(mlist[i]));
			chk("mode", 32'(mlist[i]), 32'(mode_o));
		end
		// an undefined code must leave the mode alone
		wr(core_regs_pkg::CUR_STATUS_OFF, 32'hD5);
		chk("mode kept", 32'h1B, 32'(mode_o));
		wr(core_regs_pkg::CUR_STATUS_OFF, 32'hD0);
		chk("user", 32'h21, 32'({mode_o, user_mode_o}));
		$display("test modes done");
	endtask

	task automatic t_banks;
		wr(core_regs_pkg::EXC_ENTRY_OFF, 32'h2);
		for (int i = 0; i < 6; i++) begin
			wr(core_regs_pkg::CUR_STATUS_OFF, 32'hC0 | 32'(mlist[i]));
			wr(gpr(8), 32'h800 + i);
			wr(gpr(13), 32'hD00 + i);
		end
		// user is last, so only entry gets back to a privileged view
		wr(core_regs_pkg::EXC_ENTRY_OFF, 32'h2);
		for (int i = 0; i < 6; i++) begin
			wr(core_regs_pkg::CUR_STATUS_OFF, 32'hC0 | 32'(mlist[i]));
			rchk("r8", gpr(8), (i == 0) ? 32'h800 : 32'h805);
			rchk("r13", gpr(13), 32'hD00 + i);
		end
		$display("test banks done");
	endtask

	task automatic t_entry;
		wr(core_regs_pkg::EXC_ENTRY_OFF, 32'h2);
		wr(gpr(15), 32'h00000103);
		rchk("pc", gpr(15), 32'h00000100);
		for (int k = 0; k < 5; k++) begin
			wr(core_regs_pkg::CUR_STATUS_OFF, 32'hA0000010);
			wr(core_regs_pkg::EXC_ENTRY_OFF, 32'(k));
			chk("entry mode", 32'(mlist[k]), 32'(mode_o));
			rchk("saved", core_regs_pkg::SAVED_STATUS_OFF, 32'hA0000010);
			rchk("link", gpr(14), 32'h104);
			rchk("masks", core_regs_pkg::CUR_STATUS_OFF,
				32'hA0000080 | (k == 0 ? 32'h40 : 32'h0) | 32'(mlist[k]));
		end
		// an entry kind above the five is ignored
		wr(core_regs_pkg::EXC_ENTRY_OFF, 32'h5);
		chk("kind refused", 32'h1B, 32'(mode_o));
		$display("test entry done");
	endtask

	task automatic t_masks;
		for (int k = 0; k < 2; k++) begin
			wr(core_regs_pkg::CUR_STATUS_OFF, 32'h00000010);
			wr(core_regs_pkg::EXC_ENTRY_OFF, 32'(k));
			rchk("status", core_regs_pkg::CUR_STATUS_OFF, (k == 0) ? 32'hD1 : 32'h92);
		end
		wr(core_regs_pkg::LINK_CMD_OFF, 32'h0);
		rchk("link copy", gpr(14), 32'h100);
		$display("test masks done");
	endtask

	task automatic t_user;
		wr(core_regs_pkg::CUR_STATUS_OFF, 32'h00000010);
		rchk("saved user", core_regs_pkg::SAVED_STATUS_OFF, 32'h0);
		wr(core_regs_pkg::LINK_CMD_OFF, 32'h0);
		rchk("link user", gpr(14), 32'h100);
		wr(core_regs_pkg::SAVED_STATUS_OFF, 32'hFFFFFFFF);
		wr(core_regs_pkg::CUR_STATUS_OFF, 32'h500000D3);
		rchk("user status", core_regs_pkg::CUR_STATUS_OFF, 32'h50000010);
		wr(core_regs_pkg::EXC_ENTRY_OFF, 32'h2);
		rchk("saved svc", core_regs_pkg::SAVED_STATUS_OFF, 32'h50000010);
		// read-modify-write keeps the control and reserved bits as they were
		rchk("svc status", core_regs_pkg::CUR_STATUS_OFF, 32'h50000093);
		wr(core_regs_pkg::CUR_STATUS_OFF, (rv & 32'h0FFFFFFF) | 32'h80000000);
		rchk("flags only", core_regs_pkg::CUR_STATUS_OFF, 32'h80000093);
		$display("test user done");
	endtask

	task automatic t_cond;
		logic [31:0] fl [5] = '{32'h400000D3, 32'h400000D3, 32'h400000D3, 32'h000000D3, 32'h000000D3};
		logic [31:0] cc [5] = '{32'h0, 32'h1, 32'hE, 32'h0, 32'h1};
		logic ex [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 5; i++) begin
			wr(core_regs_pkg::CUR_STATUS_OFF, fl[i]);
			wr(core_regs_pkg::COND_TEST_OFF, cc[i]);
			chk("cond", 32'(ex[i]), 32'(cond_pass_o));
		end
		$display("test cond done");
	endtask

	task automatic t_irq;
		@(posedge sys_clk_i);
		irq_req_i <= 1'b1;
		fiq_req_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk("pend masked", 32'h0, 32'({fiq_pending_o, irq_pending_o}));
		wr(core_regs_pkg::CUR_STATUS_OFF, 32'h00000093);
		@(posedge sys_clk_i);
		#1;
		chk("pend irq masked", 32'h2, 32'({fiq_pending_o, irq_pending_o}));
		wr(core_regs_pkg::CUR_STATUS_OFF, 32'h00000013);
		@(posedge sys_clk_i);
		#1;
		chk("pend open", 32'h3, 32'({fiq_pending_o, irq_pending_o}));
		irq_req_i <= 1'b0;
		fiq_req_i <= 1'b0;
		wr(core_regs_pkg::CUR_STATUS_OFF, 32'h000000D3);
		$display("test irq done");
	endtask

	task automatic t_cfg_lanes;
		@(posedge sys_clk_i);
		big_endian_i <= 1'b1;
		program_space_wide_select_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk("config", 32'h5, 32'(config_o));
		// last condition test passed, no request pending
		rchk("config reg", core_regs_pkg::CONFIG_OFF, 32'hD);
		rchk("pc big", gpr(15), 32'h100);
		@(posedge sys_clk_i);
		program_space_wide_select_i <= 1'b1;
		for (int b = 0; b < 2; b++) begin
			for (int s = 0; s < 8; s++) begin
				@(posedge sys_clk_i);
				big_endian_i <= b[0];
				acc_valid_i <= 1'b1;
				acc_byte_i <= ~s[2];
				acc_addr_i <= s[1:0];
				@(posedge sys_clk_i);
				acc_valid_i <= 1'b0;
				#1;
				chk("lanes", 32'(lane_expect), 32'(lane_en_o));
			end
		end
		$display("test lanes done");
	endtask

	// -------------------------------------------------
	// main sequence and watchdog
	// -------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		t_reset();
		t_modes();
		t_banks();
		t_entry();
		t_masks();
		t_user();
		t_cond();
		t_irq();
		t_cfg_lanes();
		stop_test();
	end

	// cuts a hang short well inside the cycle budget
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		$display("Error watchdog expected done seen running");
		stop_test();
	end
endmodule
